// ### rtl/idcu_cfg.svh
// Offsets, field positions, reset values and counts for the divide/compare unit.
// Assumes a 64-bit core word and a 32-bit condition register with eight 4-bit fields.
`ifndef IDCU_CFG_SVH
`define IDCU_CFG_SVH

// ==========================================================
// Register map
`define IDCU_ADDR_W 8
`define IDCU_OFS_COND 8'h00
`define IDCU_OFS_EXC 8'h04
`define IDCU_OFS_STATUS 8'h08
`define IDCU_OFS_MASK 8'h0C
`define IDCU_OFS_CTRL 8'h10
`define IDCU_OFS_RES_LO 8'h14
`define IDCU_OFS_RES_HI 8'h18

// ==========================================================
// Field positions
`define IDCU_EXC_SO_BIT 31
`define IDCU_EXC_OVF_BIT 30
`define IDCU_CTRL_IMPL64_BIT 0
`define IDCU_EV_DONE 0
`define IDCU_EV_OVF 1
`define IDCU_EV_INVAL 2
`define IDCU_EV_W 3
`define IDCU_COND_FIELDS 8
`define IDCU_HALF_SIGN 31

// ==========================================================
// Reset values and counts
`define IDCU_RST_COND 32'h0000_0000
`define IDCU_RST_CTRL 1'b1
`define IDCU_RST_MASK 3'h0
`define IDCU_XLEN 64

`endif

// ### rtl/idcu_pkg.sv
// Types shared by the divide/compare unit.
// Assumes the decoder presents one operation code per request.
package idcu_pkg;

    // ==========================================================
    // Operation codes
    typedef enum logic [3:0] {
        IDCU_OP_DIVD = 4'h0,
        IDCU_OP_DIVWU = 4'h1,
        IDCU_OP_DIVDU = 4'h2,
        IDCU_OP_CMPI = 4'h3,
        IDCU_OP_CMP = 4'h4,
        IDCU_OP_CMPLI = 4'h5,
        IDCU_OP_CMPL = 4'h6,
        IDCU_OP_SUBF = 4'h7
    } idcu_op_e;

    // ==========================================================
    // Sequencer states
    typedef enum logic [2:0] {
        IDCU_ST_IDLE = 3'b001,
        IDCU_ST_DIV = 3'b010,
        IDCU_ST_FIN = 3'b100
    } idcu_state_e;

endpackage

// ### rtl/idcu_div.sv
// Iterative unsigned restoring divider, one quotient bit per clock.
// Assumes the caller starts it only when idle and keeps the divisor nonzero.
`timescale 1ns/1ps
module idcu_div #(
    parameter int WIDTH = 64
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_start,
    input wire logic [WIDTH-1:0] i_dividend,
    input wire logic [WIDTH-1:0] i_divisor,
    output logic o_done,
    output logic [WIDTH-1:0] o_quot
);
    localparam int CW = $clog2(WIDTH + 1);

    generate
        if (WIDTH < 2) begin : g_chk
            $error("idcu_div needs WIDTH of at least 2");
        end
    endgenerate

    logic [WIDTH-1:0] rem_ff;
    logic [WIDTH-1:0] dvs_ff;
    logic [CW-1:0] cnt_ff;
    logic busy_ff;
    logic [WIDTH:0] trial;
    logic [WIDTH:0] shifted;

    assign shifted = {rem_ff, o_quot[WIDTH-1]};
    assign trial = shifted - {1'b0, dvs_ff};

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rem_ff <= '0;
            o_quot <= '0;
            dvs_ff <= '0;
        end else if (i_start) begin
            rem_ff <= '0;
            o_quot <= i_dividend;
            dvs_ff <= i_divisor;
        end else if (busy_ff) begin
            // Borrow out of the trial means the divisor did not fit
            rem_ff <= trial[WIDTH] ? shifted[WIDTH-1:0] : trial[WIDTH-1:0];
            o_quot <= {o_quot[WIDTH-2:0], ~trial[WIDTH]};
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_ff <= '0;
            busy_ff <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= busy_ff && (cnt_ff == CW'(1));
            if (i_start) begin
                cnt_ff <= CW'(WIDTH);
                busy_ff <= 1'b1;
            end else if (busy_ff) begin
                cnt_ff <= cnt_ff - CW'(1);
                busy_ff <= (cnt_ff != CW'(1));
            end
        end
    end

endmodule

// ### rtl/idcu_top.sv
// Integer divide, subtract-from and compare unit with its condition and exception bits.
// Assumes the decoder holds a request for one cycle and waits while busy is high.
`timescale 1ns/1ps
`include "idcu_cfg.svh"
module idcu_top
    import idcu_pkg::*;
#(
    parameter int XLEN = `IDCU_XLEN
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_op_valid,
    input wire idcu_op_e i_op_code,
    input wire logic i_len,
    input wire logic i_record,
    input wire logic i_ovf_en,
    input wire logic [2:0] i_target_cond_field,
    input wire logic [XLEN-1:0] i_first_source_reg,
    input wire logic [XLEN-1:0] i_second_source_reg,
    input wire logic [15:0] i_signed_immediate,
    input wire logic [15:0] i_unsigned_immediate,
    input wire logic [`IDCU_ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wr_data,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    output logic o_busy,
    output logic o_done,
    output logic o_invalid,
    output logic [XLEN-1:0] o_result,
    output logic [31:0] o_condition_register,
    output logic o_overflow_bit,
    output logic o_summary_overflow,
    output logic [31:0] o_rd_data,
    output logic o_irq
);
    localparam int HW = XLEN / 2;

    generate
        if (XLEN != 64) begin : g_chk
            $error("idcu_top supports only a 64-bit word");
        end
    endgenerate

    // ==========================================================
    // Helpers
    function automatic logic [2:0] order3(input logic [XLEN-1:0] a, input logic [XLEN-1:0] b,
                                          input logic sgn);
        logic lt;
        logic gt;
        lt = sgn ? ($signed(a) < $signed(b)) : (a < b);
        gt = sgn ? ($signed(a) > $signed(b)) : (a > b);
        // One-hot by construction: equal only when neither order holds
        return {lt, gt, !lt && !gt};
    endfunction

    function automatic logic [XLEN-1:0] ext_half(input logic [XLEN-1:0] v, input logic sgn);
        // Sign taken from big-endian bit 32, the top of the low word
        return {{HW{sgn & v[`IDCU_HALF_SIGN]}}, v[HW-1:0]};
    endfunction

    // ==========================================================
    // State
    idcu_state_e state_ff;
    idcu_state_e nxt_state;
    logic rec_ff;
    logic ovf_en_ff;
    logic neg_ff;
    logic word_ff;
    logic [31:0] cond_ff;
    logic so_ff;
    logic ovf_ff;
    logic impl64_ff;
    logic [`IDCU_EV_W-1:0] status_ff;
    logic [`IDCU_EV_W-1:0] mask_ff;

    // ==========================================================
    // Operand shaping
    logic [XLEN-1:0] op_a;
    logic [XLEN-1:0] op_b;
    logic is_signed_cmp;
    logic is_reg_cmp;
    logic [XLEN-1:0] cmp_a;
    logic [XLEN-1:0] cmp_b;
    logic [XLEN-1:0] imm_ext;
    logic [2:0] cmp_bits;
    logic [XLEN-1:0] diff;
    logic sub_ovf;
    logic div_sgn;
    logic div_word;
    logic [XLEN-1:0] dvd;
    logic [XLEN-1:0] dvs;
    logic div_ovf;
    logic [XLEN-1:0] mag_dvd;
    logic [XLEN-1:0] mag_dvs;
    logic div_done;
    logic [XLEN-1:0] div_quot;
    logic [XLEN-1:0] quot_fix;

    assign op_a = i_first_source_reg;
    assign op_b = i_second_source_reg;
    assign is_signed_cmp = (i_op_code == IDCU_OP_CMPI) || (i_op_code == IDCU_OP_CMP);
    assign is_reg_cmp = (i_op_code == IDCU_OP_CMP) || (i_op_code == IDCU_OP_CMPL);
    // Signed immediate is sign-extended, unsigned one zero-extended
    assign imm_ext = is_signed_cmp ? {{(XLEN-16){i_signed_immediate[15]}}, i_signed_immediate}
                                   : {{(XLEN-16){1'b0}}, i_unsigned_immediate};
    // Short operands are the low words, extended to match the ordering
    assign cmp_a = i_len ? op_a : ext_half(op_a, is_signed_cmp);
    assign cmp_b = !is_reg_cmp ? imm_ext : (i_len ? op_b : ext_half(op_b, is_signed_cmp));
    assign cmp_bits = order3(cmp_a, cmp_b, is_signed_cmp);

    assign diff = op_b - op_a;
    assign sub_ovf = (op_a[XLEN-1] != op_b[XLEN-1]) && (diff[XLEN-1] != op_b[XLEN-1]);

    assign div_sgn = (i_op_code == IDCU_OP_DIVD);
    assign div_word = (i_op_code == IDCU_OP_DIVWU);
    // Word form divides zero-extended low words; doubleword forms use full registers
    assign dvd = div_word ? {{HW{1'b0}}, op_a[HW-1:0]} : op_a;
    assign dvs = div_word ? {{HW{1'b0}}, op_b[HW-1:0]} : op_b;
    assign div_ovf = (dvs == '0) ||
                     (div_sgn && (dvd == {1'b1, {(XLEN-1){1'b0}}}) && (&dvs));
    assign mag_dvd = (div_sgn && dvd[XLEN-1]) ? (~dvd + XLEN'(1)) : dvd;
    assign mag_dvs = (div_sgn && dvs[XLEN-1]) ? (~dvs + XLEN'(1)) : dvs;

    // ==========================================================
    // Completion decode, shared by single-cycle ops and the divide tail
    logic fin_vld;
    logic fin_res_we;
    logic [XLEN-1:0] fin_res;
    logic fin_cr_we;
    logic [2:0] fin_field;
    logic [2:0] fin_bits;
    logic fin_ovf_we;
    logic fin_ovf;
    logic fin_inval;
    logic div_start;
    logic so_now;

    assign quot_fix = neg_ff ? (~div_quot + XLEN'(1)) : div_quot;

    always_comb begin
        fin_vld = 1'b0;
        fin_res_we = 1'b0;
        fin_res = '0;
        fin_cr_we = 1'b0;
        fin_field = 3'h0;
        fin_bits = 3'h0;
        fin_ovf_we = 1'b0;
        fin_ovf = 1'b0;
        fin_inval = 1'b0;
        div_start = 1'b0;
        if ((state_ff == IDCU_ST_IDLE) && i_op_valid) begin
            case (i_op_code)
                IDCU_OP_CMPI, IDCU_OP_CMP, IDCU_OP_CMPLI, IDCU_OP_CMPL: begin
                    if (i_len && !impl64_ff) begin
                        fin_inval = 1'b1;
                    end else begin
                        fin_vld = 1'b1;
                        fin_cr_we = 1'b1;
                        fin_field = i_target_cond_field;
                        fin_bits = cmp_bits;
                    end
                end
                IDCU_OP_SUBF: begin
                    fin_vld = 1'b1;
                    fin_res_we = 1'b1;
                    fin_res = diff;
                    fin_cr_we = i_record;
                    fin_bits = order3(diff, '0, 1'b1);
                    fin_ovf_we = i_ovf_en;
                    fin_ovf = sub_ovf;
                end
                IDCU_OP_DIVD, IDCU_OP_DIVDU, IDCU_OP_DIVWU: begin
                    if (!impl64_ff && !div_word) begin
                        // Doubleword divide has no meaning on a 32-bit implementation
                        fin_inval = 1'b1;
                    end else if (div_ovf) begin
                        // Quotient undefined; zero is returned without iterating
                        fin_vld = 1'b1;
                        fin_res_we = 1'b1;
                        fin_cr_we = i_record;
                        fin_bits = 3'b001;
                        fin_ovf_we = i_ovf_en;
                        fin_ovf = 1'b1;
                    end else begin
                        div_start = 1'b1;
                    end
                end
                default: begin
                    fin_inval = 1'b1;
                end
            endcase
        end else if (state_ff == IDCU_ST_FIN) begin
            fin_vld = 1'b1;
            fin_res_we = 1'b1;
            // Upper half of a word quotient is left as zero
            fin_res = word_ff ? {{HW{1'b0}}, quot_fix[HW-1:0]} : quot_fix;
            fin_cr_we = rec_ff;
            fin_bits = order3(fin_res, '0, 1'b1);
            fin_ovf_we = ovf_en_ff;
            fin_ovf = 1'b0;
        end
    end

    // Compare sees the bit as it stands; a divide sees its own update
    assign so_now = fin_ovf_we ? (so_ff | fin_ovf) : so_ff;

    // ==========================================================
    // Sequencer
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            IDCU_ST_IDLE: begin
                if (div_start) begin
                    nxt_state = IDCU_ST_DIV;
                end
            end
            IDCU_ST_DIV: begin
                if (div_done) begin
                    nxt_state = IDCU_ST_FIN;
                end
            end
            IDCU_ST_FIN: begin
                nxt_state = IDCU_ST_IDLE;
            end
            default: begin
                nxt_state = IDCU_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_ff <= IDCU_ST_IDLE;
            o_busy <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            o_busy <= (nxt_state != IDCU_ST_IDLE);
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rec_ff <= 1'b0;
            ovf_en_ff <= 1'b0;
            neg_ff <= 1'b0;
            word_ff <= 1'b0;
        end else if (div_start) begin
            rec_ff <= i_record;
            ovf_en_ff <= i_ovf_en;
            neg_ff <= div_sgn && (dvd[XLEN-1] ^ dvs[XLEN-1]);
            word_ff <= div_word;
        end
    end

    idcu_div #(
        .WIDTH(XLEN)
    ) u_div (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_start(div_start),
        .i_dividend(mag_dvd),
        .i_divisor(mag_dvs),
        .o_done(div_done),
        .o_quot(div_quot)
    );

    // ==========================================================
    // Results
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_result <= '0;
            o_done <= 1'b0;
            o_invalid <= 1'b0;
        end else begin
            o_done <= fin_vld;
            o_invalid <= fin_inval;
            if (fin_res_we) begin
                o_result <= fin_res;
            end
        end
    end

    // Hardware update wins over a software write in the same cycle
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cond_ff <= `IDCU_RST_COND;
        end else if (fin_cr_we) begin
            cond_ff[31 - 4 * fin_field -: 4] <= {fin_bits, so_now};
        end else if (i_wr_en && (i_addr == `IDCU_OFS_COND)) begin
            cond_ff <= i_wr_data;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            so_ff <= 1'b0;
            ovf_ff <= 1'b0;
        end else if (fin_ovf_we) begin
            ovf_ff <= fin_ovf;
            so_ff <= so_ff | fin_ovf;
        end else if (i_wr_en && (i_addr == `IDCU_OFS_EXC)) begin
            ovf_ff <= i_wr_data[`IDCU_EXC_OVF_BIT];
            so_ff <= i_wr_data[`IDCU_EXC_SO_BIT];
        end
    end

    assign o_condition_register = cond_ff;
    assign o_overflow_bit = ovf_ff;
    assign o_summary_overflow = so_ff;

    // ==========================================================
    // Control, interrupt status and mask
    logic [`IDCU_EV_W-1:0] events;
    logic [`IDCU_EV_W-1:0] nxt_status;

    assign events = {fin_inval, fin_ovf_we & fin_ovf, fin_vld};
    // A read clears the bits it saw; events of the same cycle survive
    assign nxt_status = ((i_rd_en && (i_addr == `IDCU_OFS_STATUS)) ? '0 : status_ff) | events;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            impl64_ff <= `IDCU_RST_CTRL;
            mask_ff <= `IDCU_RST_MASK;
        end else if (i_wr_en) begin
            if (i_addr == `IDCU_OFS_CTRL) begin
                impl64_ff <= i_wr_data[`IDCU_CTRL_IMPL64_BIT];
            end
            if (i_addr == `IDCU_OFS_MASK) begin
                mask_ff <= i_wr_data[`IDCU_EV_W-1:0];
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            status_ff <= '0;
            o_irq <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            o_irq <= |(nxt_status & mask_ff);
        end
    end

    // ==========================================================
    // Read port: data valid only in the cycle after the strobe
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rd_data <= 32'h0000_0000;
        end else if (i_rd_en) begin
            case (i_addr)
                `IDCU_OFS_COND: o_rd_data <= cond_ff;
                `IDCU_OFS_EXC: o_rd_data <= {so_ff, ovf_ff, 30'h0000_0000};
                `IDCU_OFS_STATUS: o_rd_data <= {29'h0000_0000, status_ff};
                `IDCU_OFS_MASK: o_rd_data <= {29'h0000_0000, mask_ff};
                `IDCU_OFS_CTRL: o_rd_data <= {31'h0000_0000, impl64_ff};
                `IDCU_OFS_RES_LO: o_rd_data <= o_result[31:0];
                `IDCU_OFS_RES_HI: o_rd_data <= o_result[XLEN-1:32];
                default: o_rd_data <= 32'h0000_0000;
            endcase
        end else begin
            o_rd_data <= 32'h0000_0000;
        end
    end

endmodule

// ### bench/idcu_chk_sva.sv
// Concurrent checks for the divide/compare unit, seeing only its top-level ports.
// Assumes the op codes of idcu_pkg and one request in flight at a time.
`timescale 1ns/1ps
module idcu_chk
    import idcu_pkg::*;
#(
    parameter int XLEN = 64
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_op_valid,
    input wire idcu_op_e i_op_code,
    input wire logic i_record,
    input wire logic i_ovf_en,
    input wire logic [2:0] i_target_cond_field,
    input wire logic [XLEN-1:0] i_first_source_reg,
    input wire logic [XLEN-1:0] i_second_source_reg,
    input wire logic o_busy,
    input wire logic o_done,
    input wire logic o_invalid,
    input wire logic [XLEN-1:0] o_result,
    input wire logic [31:0] o_condition_register,
    input wire logic o_overflow_bit,
    input wire logic o_summary_overflow
);
    // ==========================================================
    // Helpers
    logic [2:0] fld_ff;
    wire acc = i_op_valid && !o_busy;
    wire is_cmp = i_op_code inside {IDCU_OP_CMPI, IDCU_OP_CMP, IDCU_OP_CMPLI, IDCU_OP_CMPL};
    wire is_div = i_op_code inside {IDCU_OP_DIVD, IDCU_OP_DIVWU, IDCU_OP_DIVDU};
    wire fin = o_done || o_invalid;
    wire [3:0] fld = o_condition_register[31-4*fld_ff -: 4];
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fld_ff <= 3'h0;
        end else if (acc) begin
            fld_ff <= i_target_cond_field;
        end
    end
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    // ==========================================================
    // Assertions
    a_cmp_one_hot: assert property (acc && is_cmp |=> o_invalid || $onehot(fld[3:1]))
        else $error("compare field not one-hot");
    a_so_copy: assert property (acc && is_cmp |=> o_invalid || fld[0] == $past(o_summary_overflow))
        else $error("summary overflow not copied");
    a_reg_equal: assert property (acc && i_op_code inside {IDCU_OP_CMP, IDCU_OP_CMPL} &&
        i_first_source_reg == i_second_source_reg |=> o_invalid || fld[3:1] == 3'h1)
        else $error("equal registers not flagged equal");
    a_cr_untouched: assert property (acc && is_div && !i_record |=>
        $stable(o_condition_register) until_with fin) else $error("plain divide changed cond");
    a_ov_untouched: assert property (acc && is_div && !i_ovf_en |=>
        $stable(o_overflow_bit) until_with fin) else $error("plain divide changed ovf");
    a_div_bounded: assert property (acc && is_div |-> ##[1:67] fin)
        else $error("divide did not finish in time");
    a_zero_div_ovf: assert property (acc && is_div && i_ovf_en &&
        (i_op_code == IDCU_OP_DIVWU ? i_second_source_reg[31:0] == 32'h0 : i_second_source_reg == '0)
        |=> o_invalid || (o_overflow_bit && o_summary_overflow)) else $error("zero divide no OV");
    a_subf_value: assert property (acc && i_op_code == IDCU_OP_SUBF |=>
        o_result == $past(i_second_source_reg) - $past(i_first_source_reg))
        else $error("subtract-from result wrong");
    c_cmp: cover property (acc && is_cmp);
    c_div_done: cover property (o_done && $past(o_busy));
    c_invalid: cover property (o_invalid);
endmodule
bind idcu_top idcu_chk #(.XLEN(XLEN)) u_chk (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_op_valid(i_op_valid), .i_op_code(i_op_code), .i_record(i_record), .i_ovf_en(i_ovf_en),
    .i_target_cond_field(i_target_cond_field), .i_first_source_reg(i_first_source_reg),
    .i_second_source_reg(i_second_source_reg), .o_busy(o_busy), .o_done(o_done),
    .o_invalid(o_invalid), .o_result(o_result), .o_condition_register(o_condition_register),
    .o_overflow_bit(o_overflow_bit), .o_summary_overflow(o_summary_overflow));

// ### bench/idcu_dec_model.sv
// Decoder and register-file stand-in that presents one request at a time.
// Assumes the unit takes a request at an edge where busy is low.
`timescale 1ns/1ps
module idcu_dec_model
    import idcu_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_busy,
    output logic o_op_valid,
    output idcu_op_e o_op_code,
    output logic o_len,
    output logic o_record,
    output logic o_ovf_en,
    output logic [2:0] o_target_cond_field,
    output logic [63:0] o_first_source_reg,
    output logic [63:0] o_second_source_reg,
    output logic [15:0] o_signed_immediate,
    output logic [15:0] o_unsigned_immediate
);
    initial begin
        {o_op_valid, o_len, o_record, o_ovf_en, o_target_cond_field} = '0;
        {o_first_source_reg, o_second_source_reg} = '0;
        {o_signed_immediate, o_unsigned_immediate} = '0;
        o_op_code = IDCU_OP_CMP;
    end
    // ==========================================================
    // Request issue
    task automatic issue(input idcu_op_e op, input logic l, input logic r, input logic o,
        input logic [2:0] f, input logic [63:0] a, input logic [63:0] b, input logic [15:0] imm);
        @(posedge i_ref_clk);
        #1;
        while (i_busy) begin
            @(posedge i_ref_clk);
            #1;
        end
        o_op_valid <= 1'b1;
        o_op_code <= op;
        {o_len, o_record, o_ovf_en} <= {l, r, o};
        o_target_cond_field <= f;
        {o_first_source_reg, o_second_source_reg} <= {a, b};
        {o_signed_immediate, o_unsigned_immediate} <= {imm, imm};
        @(posedge i_ref_clk);
        #1;
        o_op_valid <= 1'b0;
        // Released operands go stale on purpose, never the last value
        {o_first_source_reg, o_second_source_reg} <= {~a, ~b};
        {o_signed_immediate, o_unsigned_immediate} <= {~imm, ~imm};
    endtask
endmodule

// ### bench/idcu_bench.sv
// Self-checking bench for the divide/compare unit.
// Assumes the decoder model drives the operation port and the bench the register port.
`timescale 1ns/1ps
module idcu_bench;
    import idcu_pkg::*;
    logic i_ref_clk, i_rst_n, i_wr_en, i_rd_en, op_valid, len, rec, ovf, busy, done, inval;
    logic ovb, so, irq;
    logic [7:0] i_addr;
    logic [31:0] i_wr_data, rd_data, cnd;
    logic [2:0] fld;
    idcu_op_e code;
    logic [63:0] opa, opb, res;
    logic [15:0] signed_immediate, unsigned_immediate;
    int failures, num_checks, cyc;

    idcu_dec_model u_dec (.i_ref_clk(i_ref_clk), .i_busy(busy), .o_op_valid(op_valid),
        .o_op_code(code), .o_len(len), .o_record(rec), .o_ovf_en(ovf),
        .o_target_cond_field(fld), .o_first_source_reg(opa), .o_second_source_reg(opb),
        .o_signed_immediate(signed_immediate), .o_unsigned_immediate(unsigned_immediate));
    idcu_top u_dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_op_valid(op_valid),
        .i_op_code(code), .i_len(len), .i_record(rec), .i_ovf_en(ovf),
        .i_target_cond_field(fld), .i_first_source_reg(opa), .i_second_source_reg(opb),
        .i_signed_immediate(signed_immediate), .i_unsigned_immediate(unsigned_immediate), .i_addr(i_addr),
        .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_busy(busy),
        .o_done(done), .o_invalid(inval), .o_result(res), .o_condition_register(cnd),
        .o_overflow_bit(ovb), .o_summary_overflow(so), .o_rd_data(rd_data), .o_irq(irq));

    initial begin
        i_ref_clk = 1'b0;
        forever #25 i_ref_clk = ~i_ref_clk;
    end
    // Run is well under 2000 cycles; the ceiling only cuts a hang
    always @(posedge i_ref_clk) begin
        cyc++;
        if (cyc == 6000) begin
            failures++;
            end_sim();
        end
    end

    // ==========================================================
    // Tasks
    task automatic end_sim();
        if (failures == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic bit1(input logic got, input logic exp);
        check({63'h0, got}, {63'h0, exp});
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        {i_addr, i_wr_data, i_wr_en} <= {a, d, 1'b1};
        @(posedge i_ref_clk);
        i_wr_en <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_ref_clk);
        {i_addr, i_rd_en} <= {a, 1'b1};
        @(posedge i_ref_clk);
        i_rd_en <= 1'b0;
        #1;
        check({32'h0, rd_data}, {32'h0, exp});
    endtask
    task automatic run(input idcu_op_e op, input logic l, input logic r, input logic o,
        input logic [2:0] f, input logic [63:0] a, input logic [63:0] b, input logic [15:0] imm);
        int n;
        u_dec.issue(op, l, r, o, f, a, b, imm);
        for (n = 0; n < 80 && done !== 1'b1 && inval !== 1'b1; n++) begin
            @(posedge i_ref_clk);
            #1;
        end
        bit1(n < 80, 1'b1);
    endtask
    task automatic cmp(input idcu_op_e op, input logic l, input logic [2:0] f,
        input logic [63:0] a, input logic [63:0] b, input logic [15:0] imm, input logic [3:0] e);
        run(op, l, 1'b0, 1'b0, f, a, b, imm);
        check({60'h0, cnd[31-4*f -: 4]}, {60'h0, e});
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        {i_rst_n, i_wr_en, i_rd_en, i_addr, i_wr_data} = '0;
        {failures, num_checks, cyc} = '0;
        repeat (4) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        reg_rd(8'h00, 32'h0);
        reg_rd(8'h04, 32'h0);
        reg_rd(8'h10, 32'h1);
        reg_rd(8'h20, 32'h0);
        reg_wr(8'h0C, 32'h7);
        cmp(IDCU_OP_CMP, 1'b0, 3'h1, 64'h8000_0000, 64'h1, 16'h0, 4'h8);
        cmp(IDCU_OP_CMPL, 1'b0, 3'h2, 64'h8000_0000, 64'h1, 16'h0, 4'h4);
        cmp(IDCU_OP_CMP, 1'b1, 3'h3, 64'h8000_0000, 64'h1, 16'h0, 4'h4);
        cmp(IDCU_OP_CMP, 1'b0, 3'h4, 64'h1_0000_0007, 64'h7, 16'h0, 4'h2);
        cmp(IDCU_OP_CMPI, 1'b0, 3'h5, 64'hFFFF_FFFF, 64'h0, 16'hFFFF, 4'h2);
        cmp(IDCU_OP_CMPI, 1'b1, 3'h6, 64'hFFFF_FFFF, 64'h0, 16'hFFFF, 4'h4);
        cmp(IDCU_OP_CMPLI, 1'b0, 3'h7, 64'h1_0000_0005, 64'h0, 16'h5, 4'h2);
        cmp(IDCU_OP_CMPLI, 1'b1, 3'h0, 64'h1_0000_0005, 64'h0, 16'h5, 4'h4);
        cmp(IDCU_OP_CMPL, 1'b1, 3'h1, 64'h1, '1, 16'h0, 4'h8);
        bit1(irq, 1'b1);
        reg_rd(8'h08, 32'h1);
        bit1(irq, 1'b0);
        reg_wr(8'h0C, 32'h2);
        run(IDCU_OP_DIVD, 1'b0, 1'b1, 1'b0, 3'h0, 64'hFFFF_FFFF_FFFF_FFF9, 64'h2, 16'h0);
        check(res, 64'hFFFF_FFFF_FFFF_FFFD);
        check({60'h0, cnd[31:28]}, 64'h8);
        run(IDCU_OP_DIVWU, 1'b0, 1'b0, 1'b0, 3'h0, 64'hFFFF_FFFF_0000_0010, 64'h5_0000_0002, 16'h0);
        check(res, 64'h8);
        check({60'h0, cnd[31:28]}, 64'h8);
        run(IDCU_OP_DIVDU, 1'b0, 1'b0, 1'b0, 3'h0, 64'hFFFF_FFFF_FFFF_FFFE, 64'h2, 16'h0);
        check(res, 64'h7FFF_FFFF_FFFF_FFFF);
        bit1(irq, 1'b0);
        run(IDCU_OP_DIVDU, 1'b0, 1'b1, 1'b1, 3'h0, 64'h5, 64'h0, 16'h0);
        check({res[63:32], 28'h0, cnd[31:28]}, 64'h3);
        bit1(irq, 1'b1);
        reg_rd(8'h04, 32'hC000_0000);
        reg_rd(8'h08, 32'h3);
        bit1(irq, 1'b0);
        run(IDCU_OP_DIVD, 1'b0, 1'b0, 1'b1, 3'h0, 64'h8000_0000_0000_0000, '1, 16'h0);
        bit1(ovb, 1'b1);
        run(IDCU_OP_DIVDU, 1'b0, 1'b0, 1'b1, 3'h0, 64'h9, 64'h3, 16'h0);
        check({res[61:0], ovb, so}, {62'h3, 2'b01});
        cmp(IDCU_OP_CMP, 1'b0, 3'h2, 64'h1, 64'h1, 16'h0, 4'h3);
        run(IDCU_OP_SUBF, 1'b0, 1'b0, 1'b0, 3'h0, 64'h5, 64'h3, 16'h0);
        check(res, 64'hFFFF_FFFF_FFFF_FFFE);
        reg_wr(8'h10, 32'h0);
        run(IDCU_OP_CMP, 1'b1, 1'b0, 1'b0, 3'h2, 64'h1, 64'h2, 16'h0);
        check({59'h0, inval, cnd[23:20]}, {59'h0, 1'b1, 4'h3});
        cmp(IDCU_OP_CMP, 1'b0, 3'h2, 64'h1, 64'h2, 16'h0, 4'h9);
        reg_rd(8'h08, 32'h7);
        end_sim();
    end
endmodule
